// ### hw/lpt_pkg.sv
// Package: constants and types for lamp sequencing and pixel tagging
package lpt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SEQ    = 8'h04;
    localparam logic [7:0] OFS_BLACK  = 8'h08;
    localparam logic [7:0] OFS_ACTIVE = 8'h0c;
    localparam logic [7:0] OFS_LAMP0  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Field positions
    localparam int CTRL_LOCK_BIT   = 0;
    localparam int CTRL_NOCOMP_BIT = 2;
    localparam int SEQ_CNT_LSB     = 0;
    localparam int SEQ_MODE_LSB    = 3;
    localparam int SEQ_CSEL_LSB    = 5;
    // Reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_SEQ  = 32'h0000_0000;
    localparam logic [31:0] RST_WIN  = 32'h0000_0000;
    // Tag pipeline latency in pixel periods
    localparam int LAT_PIX = 8;
    // Tag codes on the low four bits
    localparam logic [3:0] TAG_DUMMY = 4'h0;
    localparam logic [3:0] TAG_ACT0  = 4'h1;
    localparam logic [3:0] TAG_BLK0  = 4'h6;
    localparam logic [3:0] TAG_BOS   = 4'hf;
    localparam int NLAMP = 4;

    typedef enum logic [1:0] {
        LPT_MODE_CCD,
        LPT_MODE_PER_CHAN,
        LPT_MODE_PER_LINE,
        LPT_MODE_RSVD
    } lpt_mode_e;

    typedef struct packed {
        logic        lock;
        logic        nocomp;
        logic [1:0]  seq_cnt;
        lpt_mode_e   mode;
        logic [1:0]  csel;
        logic [15:0] blk_start;
        logic [15:0] blk_num;
        logic [15:0] act_start;
        logic [15:0] act_end;
        logic [NLAMP-1:0][15:0] lamp_on;
        logic [NLAMP-1:0][15:0] lamp_off;
    } lpt_cfg_s;

    typedef struct packed {
        logic       scan_on;
        logic       bos_pend;
        logic [1:0] line_idx;
    } lpt_stat_s;
endpackage

// ### hw/lpt_top.sv
// Lamp sequencer and pixel tag generator behind an AHB-Lite slave
`timescale 1ns/1ps
module lpt_top
    import lpt_pkg::*;
(
    // System clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pixel clock domain inputs
    input  wire logic        i_pix_clk,
    input  wire logic        i_xfer_interval,
    input  wire logic [3:0]  i_transfer_gate,
    input  wire logic [15:0] i_pix_data,
    input  wire logic [1:0]  i_pix_chan,
    // Pixel clock domain outputs
    output logic [3:0]       o_illum,
    output logic [1:0]       o_coef_sel,
    output logic [15:0]      o_pix_word,
    output logic [4:0]       o_pixel_tag_bits
);

    // Inside-window test, wraps when off point precedes on point
    function automatic logic in_win(input logic [15:0] c,
                                    input logic [15:0] on_pt,
                                    input logic [15:0] off_pt);
        if (on_pt <= off_pt)
            return (c >= on_pt) && (c < off_pt);
        return (c >= on_pt) || (c < off_pt);
    endfunction

    // Colour of a line in per-line mode: pairs RG, RB, GB, R-IR
    function automatic logic [1:0] line_colour(input logic [1:0] csel,
                                               input logic       second);
        case (csel)
            2'h0:    return second ? 2'h1 : 2'h0;
            2'h1:    return second ? 2'h2 : 2'h0;
            2'h2:    return second ? 2'h2 : 2'h1;
            default: return second ? 2'h3 : 2'h0;
        endcase
    endfunction

    // ---------------- System clock domain ----------------
    lpt_cfg_s    cfg_reg;
    lpt_cfg_s    hold_reg;
    lpt_stat_s   stat_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        req_reg;
    logic [2:0]  ack_sync_reg;
    logic        ack_seen_reg;
    logic        addr_ok;
    logic [31:0] rd_word;
    logic [7:0]  a_ofs;
    logic        ack_reg;
    lpt_stat_s   stat_hold_reg;

    assign a_ofs   = haddr[7:0];
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    // Address phase capture for writes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= a_ofs;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (a_ofs)
            OFS_CTRL: begin
                rd_word[CTRL_LOCK_BIT]   = cfg_reg.lock;
                rd_word[CTRL_NOCOMP_BIT] = cfg_reg.nocomp;
            end
            OFS_SEQ: begin
                rd_word[SEQ_CNT_LSB +: 2]  = cfg_reg.seq_cnt;
                rd_word[SEQ_MODE_LSB +: 2] = cfg_reg.mode;
                rd_word[SEQ_CSEL_LSB +: 2] = cfg_reg.csel;
            end
            OFS_BLACK:  rd_word = {cfg_reg.blk_num, cfg_reg.blk_start};
            OFS_ACTIVE: rd_word = {cfg_reg.act_end, cfg_reg.act_start};
            OFS_STATUS: rd_word = {28'h0000000, stat_reg};
            default: begin
                for (int k = 0; k < NLAMP; k++) begin
                    if (a_ofs == OFS_LAMP0 + 8'(4 * k))
                        rd_word = {cfg_reg.lamp_off[k], cfg_reg.lamp_on[k]};
                end
            end
        endcase
    end
    // Read data registered at address phase, so zero wait states
    always_ff @(posedge i_mclk) begin
        if (i_rst)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= rd_word;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_reg.lock    <= RST_CTRL[CTRL_LOCK_BIT];
            cfg_reg.nocomp  <= RST_CTRL[CTRL_NOCOMP_BIT];
            cfg_reg.seq_cnt <= RST_SEQ[SEQ_CNT_LSB +: 2];
            cfg_reg.mode    <= lpt_mode_e'(RST_SEQ[SEQ_MODE_LSB +: 2]);
            cfg_reg.csel    <= RST_SEQ[SEQ_CSEL_LSB +: 2];
            cfg_reg.blk_start <= RST_WIN[15:0];
            cfg_reg.blk_num   <= RST_WIN[31:16];
            cfg_reg.act_start <= RST_WIN[15:0];
            cfg_reg.act_end   <= RST_WIN[31:16];
            for (int k = 0; k < NLAMP; k++) begin
                cfg_reg.lamp_on[k]  <= RST_WIN[15:0];
                cfg_reg.lamp_off[k] <= RST_WIN[31:16];
            end
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFS_CTRL: begin
                    cfg_reg.lock   <= hwdata[CTRL_LOCK_BIT];
                    cfg_reg.nocomp <= hwdata[CTRL_NOCOMP_BIT];
                end
                OFS_SEQ: begin
                    cfg_reg.seq_cnt <= hwdata[SEQ_CNT_LSB +: 2];
                    cfg_reg.mode    <= lpt_mode_e'(hwdata[SEQ_MODE_LSB +: 2]);
                    cfg_reg.csel    <= hwdata[SEQ_CSEL_LSB +: 2];
                end
                OFS_BLACK: begin
                    cfg_reg.blk_start <= hwdata[15:0];
                    cfg_reg.blk_num   <= hwdata[31:16];
                end
                OFS_ACTIVE: begin
                    cfg_reg.act_start <= hwdata[15:0];
                    cfg_reg.act_end   <= hwdata[31:16];
                end
                default: begin
                    for (int k = 0; k < NLAMP; k++) begin
                        if (wr_addr_reg == OFS_LAMP0 + 8'(4 * k)) begin
                            cfg_reg.lamp_on[k]  <= hwdata[15:0];
                            cfg_reg.lamp_off[k] <= hwdata[31:16];
                        end
                    end
                end
            endcase
        end
    end

    // Free-running handshake: config goes out, status comes back.
    // The held word only changes once the far side has acknowledged.
    always_ff @(posedge i_mclk) begin
        ack_sync_reg <= {ack_sync_reg[1:0], ack_reg};
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ack_seen_reg <= 1'b0;
            req_reg      <= 1'b0;
            hold_reg     <= '0;
            stat_reg     <= '0;
        end else begin
            if (ack_sync_reg[2] == ack_sync_reg[1])
                ack_seen_reg <= ack_sync_reg[2];
            if (ack_seen_reg == req_reg) begin
                hold_reg <= cfg_reg;
                stat_reg <= stat_hold_reg;
                req_reg  <= ~req_reg;
            end
        end
    end

    // ---------------- Pixel clock domain ----------------
    logic [2:0]  rst_sync_reg;
    logic        prst;
    logic [2:0]  req_sync_reg;
    logic        req_seen_reg;
    lpt_cfg_s    pcfg_reg;
    logic        xfer_q_reg;
    logic        lock_q_reg;
    logic        bos_pend_reg;
    logic        bos_line_reg;
    logic [1:0]  line_reg;
    logic [15:0] cnt_reg;
    logic [1:0]  len_m1;
    logic        cis_mode;
    logic [1:0]  colour;
    logic        is_black;
    logic        is_active;
    logic [4:0]  tag_now;
    logic [4:0]  tag_pipe_reg [LAT_PIX];
    logic [NLAMP-1:0] lamp_sel;
    logic [NLAMP-1:0] lamp_win;

    always_ff @(posedge i_pix_clk) begin
        rst_sync_reg <= {rst_sync_reg[1:0], i_rst};
    end
    assign prst = rst_sync_reg[2];

    always_ff @(posedge i_pix_clk) begin
        req_sync_reg <= {req_sync_reg[1:0], req_reg};
    end

    always_ff @(posedge i_pix_clk) begin
        if (prst) begin
            req_seen_reg  <= 1'b0;
            ack_reg       <= 1'b0;
            pcfg_reg      <= '0;
            stat_hold_reg <= '0;
        end else begin
            if (req_sync_reg[2] == req_sync_reg[1])
                req_seen_reg <= req_sync_reg[2];
            if (req_seen_reg != ack_reg) begin
                pcfg_reg      <= hold_reg;
                stat_hold_reg <= {pcfg_reg.lock, bos_pend_reg, line_reg};
                ack_reg       <= req_seen_reg;
            end
        end
    end

    assign cis_mode = (pcfg_reg.mode == LPT_MODE_PER_CHAN)
                   || (pcfg_reg.mode == LPT_MODE_PER_LINE);
    // CCD timing runs as a one-line sequence
    assign len_m1 = cis_mode ? pcfg_reg.seq_cnt : 2'h0;

    // Line index steps at the end of each transfer interval while lock is set, else held at zero
    always_ff @(posedge i_pix_clk) begin
        if (prst) begin
            xfer_q_reg <= 1'b0;
            line_reg   <= 2'h0;
        end else begin
            xfer_q_reg <= i_xfer_interval;
            if (!pcfg_reg.lock)
                line_reg <= 2'h0;
            else if (xfer_q_reg && !i_xfer_interval)
                line_reg <= (line_reg >= len_m1) ? 2'h0 : line_reg + 2'h1;
        end
    end

    // Post-interval pixel counter, saturating
    always_ff @(posedge i_pix_clk) begin
        if (prst)
            cnt_reg <= 16'h0000;
        else if (i_xfer_interval)
            cnt_reg <= 16'h0000;
        else if (cnt_reg != 16'hffff)
            cnt_reg <= cnt_reg + 16'h0001;
    end

    // First interval after lock rises marks beginning of scan
    always_ff @(posedge i_pix_clk) begin
        if (prst) begin
            lock_q_reg   <= 1'b0;
            bos_pend_reg <= 1'b0;
            bos_line_reg <= 1'b0;
        end else begin
            lock_q_reg <= pcfg_reg.lock;
            if (pcfg_reg.lock && !lock_q_reg)
                bos_pend_reg <= 1'b1;
            else if (i_xfer_interval && !xfer_q_reg)
                bos_pend_reg <= 1'b0;
            if (i_xfer_interval && !xfer_q_reg)
                bos_line_reg <= bos_pend_reg || (pcfg_reg.lock && !lock_q_reg);
            else if (!i_xfer_interval)
                bos_line_reg <= 1'b0;
        end
    end

    always_comb begin
        colour = i_pix_chan;
        if (pcfg_reg.mode == LPT_MODE_PER_LINE && len_m1 == 2'h1)
            colour = line_colour(pcfg_reg.csel, line_reg[0]);
        else if (cis_mode && len_m1 != 2'h0)
            colour = line_reg;
    end

    assign is_black  = (cnt_reg > pcfg_reg.blk_start)
                    && ({1'b0, cnt_reg} < {1'b0, pcfg_reg.blk_start}
                                          + {1'b0, pcfg_reg.blk_num});
    assign is_active = (cnt_reg >= pcfg_reg.act_start)
                    && (cnt_reg <= pcfg_reg.act_end);

    always_comb begin
        tag_now = {1'b0, TAG_DUMMY};
        if (i_xfer_interval)
            tag_now = {1'b1, (bos_line_reg || (!xfer_q_reg && (bos_pend_reg
                || (pcfg_reg.lock && !lock_q_reg)))) ? TAG_BOS : TAG_DUMMY};
        else if (is_black)
            tag_now = {1'b0, TAG_BLK0 + {2'h0, colour}};
        else if (is_active)
            tag_now = {1'b0, TAG_ACT0 + {2'h0, colour}};
    end

    // Tag delay line matching the conversion pipeline
    always_ff @(posedge i_pix_clk) begin
        if (prst) begin
            for (int k = 0; k < LAT_PIX; k++)
                tag_pipe_reg[k] <= 5'h00;
        end else begin
            tag_pipe_reg[0] <= tag_now;
            for (int k = 1; k < LAT_PIX; k++)
                tag_pipe_reg[k] <= tag_pipe_reg[k-1];
        end
    end

    always_ff @(posedge i_pix_clk) begin
        if (prst) begin
            o_pix_word       <= 16'h0000;
            o_pixel_tag_bits <= 5'h00;
            o_coef_sel       <= 2'h0;
        end else begin
            o_pix_word       <= i_pix_data;
            o_pixel_tag_bits <= pcfg_reg.nocomp ? tag_now
                                : tag_pipe_reg[LAT_PIX-1];
            o_coef_sel       <= colour;
        end
    end
    // Lamp selection: mono lights RGB each line, else the line colour
    generate
        for (genvar g = 0; g < NLAMP; g++) begin : g_lamp
            assign lamp_win[g] = in_win(cnt_reg, pcfg_reg.lamp_on[g],
                                        pcfg_reg.lamp_off[g]);
            assign lamp_sel[g] = (len_m1 == 2'h0) ? (g < 3)
                               : (colour == 2'(g));
        end
    endgenerate

    always_ff @(posedge i_pix_clk) begin
        if (prst)
            o_illum <= 4'h0;
        else if (!cis_mode)
            o_illum <= i_transfer_gate;
        else
            o_illum <= pcfg_reg.lock ? (lamp_sel & lamp_win) : 4'h0;
    end

endmodule

// ### verif/lamp_seq_pixel_tagging_tb.sv
// Self-checking bench for the lamp sequencer and pixel tag generator
`timescale 1ns/1ps
module lamp_seq_pixel_tagging_tb import lpt_pkg::*;;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_pix_clk = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        src_en = 1'b0;
    wire         hreadyout;
    wire  [31:0] hrdata;
    wire         iv;
    wire  [3:0]  gate;
    wire  [15:0] pdat;
    wire  [1:0]  pch;
    wire  [3:0]  illum;
    wire  [4:0]  tag;
    wire  [1:0]  csel;
    wire  [15:0] pw;
    logic [1:0]  ppch;
    logic [15:0] ppd;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] seed = 32'h576a;
    logic [31:0] rd;
    logic [15:0] bs, bn, as_, ae;
    logic [15:0] c = 16'h0;
    logic        piv = 1'b0, bos = 1'b0, kn = 1'b0, chk_on = 1'b0, comp = 1'b0, lam_on = 1'b0;
    logic [9:0][5:0] h = '0;
    logic [3:0]  acc, bad, mask, pg;
    logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_SEQ, OFS_BLACK, OFS_ACTIVE, OFS_LAMP0, OFS_STATUS};
    logic [7:0]  lseq [7] = '{8'h11, 8'h31, 8'h51, 8'h71, 8'h0a, 8'h0b, 8'h08};
    logic [3:0]  lmask [7] = '{4'h3, 4'h5, 4'h6, 4'h9, 4'h7, 4'hf, 4'h7};

    always #4 i_mclk = ~i_mclk;
    always #16 i_pix_clk = ~i_pix_clk;

    lpt_top lpt_top_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .i_pix_clk(i_pix_clk),
        .i_xfer_interval(iv), .i_transfer_gate(gate), .i_pix_data(pdat), .i_pix_chan(pch),
        .o_illum(illum), .o_coef_sel(csel), .o_pix_word(pw), .o_pixel_tag_bits(tag)
    );
    lpt_pix_src lpt_pix_src_inst (
        .i_clk(i_pix_clk), .i_rst(i_rst), .i_en(src_en),
        .o_iv(iv), .o_data(pdat), .o_chan(pch), .o_gate(gate)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [4:0] etag(input logic [15:0] cv);
        if (iv) return {1'b1, bos ? TAG_BOS : TAG_DUMMY};
        if (cv > bs && {1'b0, cv} < bs + bn) return {1'b0, TAG_BLK0 + 4'(pch)};
        if (cv >= as_ && cv <= ae) return {1'b0, TAG_ACT0 + 4'(pch)};
        return {1'b0, TAG_DUMMY};
    endfunction
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            $display("Error at %0t: seen %h expected %h", $time, s, e);
            miscompares++;
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            miscompares++;
            conclude();
        end
    endtask

    // Expected tag per pixel sample, kept deep enough for the latency path
    always @(posedge i_pix_clk) begin : pred
        logic [15:0] cv;
        logic [5:0]  d;
        cv = (iv || piv) ? 16'h0 : c + 16'h1;
        if (iv) kn = 1'b1;
        d = comp ? h[8] : h[0];
        if (chk_on && d[5]) chk(32'(tag), 32'(d[4:0]));
        if (chk_on && kn) begin
            chk(32'(csel), 32'(ppch));
            chk(32'(pw), 32'(ppd));
            chk(32'(illum), 32'(pg));
        end
        ppch <= pch;
        ppd <= pdat;
        pg <= gate;
        h <= {h[8:0], kn, etag(cv)};
        if (piv && !iv) bos <= 1'b0;
        if (lam_on) begin
            acc |= illum;
            bad |= illum & ~mask;
        end
        c <= cv;
        piv <= iv;
    end

    task automatic tagrun(input logic nc, input logic [31:0] r);
        chk_on = 1'b0;
        kn = 1'b0;
        src_en <= 1'b0;
        bs = {11'h0, r[4:0]};
        bn = {13'h0, r[7:5]};
        as_ = {11'h0, r[12:8]};
        ae = as_ + {10'h0, r[18:13]};
        ahb(1'b1, OFS_CTRL, 32'h0);
        ahb(1'b1, OFS_SEQ, 32'h0);
        ahb(1'b1, OFS_BLACK, {bn, bs});
        ahb(1'b0, OFS_BLACK, 32'h0);
        chk(rd, {bn, bs});
        ahb(1'b1, OFS_ACTIVE, {ae, as_});
        repeat (40) @(posedge i_mclk);
        ahb(1'b1, OFS_CTRL, {29'h0, nc, 2'h1});
        comp = !nc;
        bos = 1'b1;
        repeat (64) @(posedge i_mclk);
        chk_on = 1'b1;
        src_en <= 1'b1;
        repeat (1600) @(posedge i_mclk);
    endtask

    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        foreach (ofs[i]) begin
            ahb(1'b0, ofs[i], 32'h0);
            chk(rd, 32'h0);
        end
        ahb(1'b1, OFS_STATUS, 32'hf);
        ahb(1'b1, 8'h40, 32'h1234);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("Test registers done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            tagrun(i[0], (i == 0) ? 32'h0 : seed);
            $display("Test tags %0d done", i);
        end
        chk_on = 1'b0;
        for (int i = 0; i < 4; i++) ahb(1'b1, OFS_LAMP0 + 8'(4 * i), 32'hffff_0000);
        foreach (lseq[i]) begin
            ahb(1'b1, OFS_CTRL, 32'h0);
            ahb(1'b1, OFS_SEQ, {24'h0, lseq[i]});
            repeat (64) @(posedge i_mclk);
            chk(32'(illum), 32'h0);
            mask = lmask[i];
            ahb(1'b1, OFS_CTRL, 32'h1);
            repeat (200) @(posedge i_mclk);
            acc = 4'h0;
            bad = 4'h0;
            lam_on = 1'b1;
            repeat (1600) @(posedge i_mclk);
            lam_on = 1'b0;
            chk(32'(acc), 32'(mask));
            chk(32'(bad), 32'h0);
            $display("Test lamps %0d done", i);
        end
        conclude();
    end
endmodule

// ### verif/lpt_pix_src.sv
// Pixel source standing in for the sensor timing side
`timescale 1ns/1ps
module lpt_pix_src #(
    parameter int IV_LEN   = 12,
    parameter int LINE_LEN = 52
) (
    // Pixel clock and control
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_en,
    // Pixel stream
    output logic             o_iv,
    output logic [15:0]      o_data,
    output logic [1:0]       o_chan,
    output logic [3:0]       o_gate
);
    logic [7:0] pos_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_en) begin
            pos_reg <= 8'h0;
            o_iv    <= 1'b0;
        end else begin
            pos_reg <= (pos_reg == 8'(IV_LEN + LINE_LEN - 1)) ? 8'h0 : pos_reg + 8'h1;
            o_iv    <= pos_reg < 8'(IV_LEN);
        end
    end
    // Data keeps moving so a stale word never passes as fresh
    always_ff @(posedge i_clk) begin
        o_data <= i_rst ? 16'h0 : o_data + 16'h3b5d;
        o_chan <= i_rst ? 2'h0 : o_chan + 2'h1;
        o_gate <= i_rst ? 4'h0 : (pos_reg == 8'h0) ? o_gate + 4'h1 : o_gate;
    end
endmodule

// ### verif/lpt_props.sv
// Checker for bus answers and the pixel tag stream
`timescale 1ns/1ps
module lpt_props (
    // Clocks and reset
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_pix_clk,
    // Watched signals
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        i_xfer_interval,
    input wire logic [15:0] i_pix_data,
    input wire logic [15:0] o_pix_word,
    input wire logic [4:0]  o_pixel_tag_bits
);
    // Pixel side leaves reset late, so hold checks off a few edges longer
    logic [4:0] rs_reg;
    wire        prst = i_rst | (|rs_reg);
    always_ff @(posedge i_pix_clk) begin
        rs_reg <= {rs_reg[3:0], i_rst};
    end
    sequence s_iv_hi;
        i_xfer_interval [*8] ##1 i_xfer_interval;
    endsequence
    sequence s_iv_lo;
        !i_xfer_interval [*8] ##1 !i_xfer_interval;
    endsequence
    AST_BUS_OKAY: assert property (@(posedge i_mclk) disable iff (i_rst)
        hresp == 1'b0) else $error("bus response not okay");
    AST_BUS_READY: assert property (@(posedge i_mclk) disable iff (i_rst)
        1'b1 |=> hreadyout) else $error("bus not ready after reset");
    AST_WORD_FOLLOWS: assert property (@(posedge i_pix_clk) disable iff (prst)
        o_pix_word == $past(i_pix_data) || o_pix_word == $past(i_pix_data, 2))
        else $error("pixel word not passed through");
    AST_CODE_LEGAL: assert property (@(posedge i_pix_clk) disable iff (prst)
        !(o_pixel_tag_bits[3:0] inside {4'h5, 4'ha, 4'hb, 4'hc, 4'hd, 4'he}))
        else $error("illegal tag code");
    AST_BOS_IN_IV: assert property (@(posedge i_pix_clk) disable iff (prst)
        o_pixel_tag_bits[3:0] == 4'hf |-> o_pixel_tag_bits[4])
        else $error("scan start code outside interval");
    AST_IV_CODE: assert property (@(posedge i_pix_clk) disable iff (prst)
        o_pixel_tag_bits[4] |-> o_pixel_tag_bits[3:0] inside {4'h0, 4'hf})
        else $error("pixel code during interval");
    AST_IV_HI: assert property (@(posedge i_pix_clk) disable iff (prst)
        s_iv_hi |-> ##1 o_pixel_tag_bits[4]) else $error("line start bit missing");
    AST_IV_LO: assert property (@(posedge i_pix_clk) disable iff (prst)
        s_iv_lo |-> ##1 !o_pixel_tag_bits[4]) else $error("line start bit stuck");
endmodule

bind lpt_top lpt_props lpt_props_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_pix_clk(i_pix_clk), .hreadyout(hreadyout),
    .hresp(hresp), .i_xfer_interval(i_xfer_interval), .i_pix_data(i_pix_data),
    .o_pix_word(o_pix_word), .o_pixel_tag_bits(o_pixel_tag_bits)
);
